// ===== rtl/rtm_pkg.sv
// Constants, field positions and mode codes of the tag encode/modulate block.
// Assumes a 25 MHz reference clock and an APB master with 32-bit data.
package rtm_pkg;

  // Register byte offsets.
  localparam logic [7:0] CFG_ADDR    = 8'h00;
  localparam logic [7:0] CTRL_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] DATA0_ADDR  = 8'h10;
  localparam logic [7:0] DATA3_ADDR  = 8'h1C;

  // Configuration word field positions.
  localparam int CFG_WIDTH    = 12;
  localparam int LEN_BIT      = 0;
  localparam int RATE_LO_BIT  = 1;
  localparam int RATE_D_BIT   = 4;
  localparam int ENC_LO_BIT   = 5;
  localparam int MOD_LO_BIT   = 7;
  localparam int PSKDIV_BIT   = 9;
  localparam int ZERO_BIT     = 10;
  localparam int LOCK_BIT     = 11;
  localparam logic [11:0] CFG_RESET = 12'h000;

  // Control register command bit and status fields.
  localparam int CTRL_LOCK_BIT   = 0;
  localparam int STAT_LOCK_BIT   = 0;
  localparam int STAT_RUN_BIT    = 1;
  localparam int STAT_SENSOR_BIT = 2;
  localparam int STAT_CNT_LO     = 8;

  // Memory geometry.
  localparam int MEM_BITS   = 128;
  localparam int SHORT_BITS = 96;
  localparam int FIFO_DEPTH = 16;

  // FSK subcarrier divisors of the carrier for a one and a zero.
  localparam logic [7:0] FSK_ONE_DIV  = 8'h0A;
  localparam logic [7:0] FSK_ZERO_DIV = 8'h08;

  typedef enum logic [1:0] {
    ENC_DIRECT, ENC_DIFF_BIPHASE, ENC_MANCHESTER, ENC_MANCH_VARIANT
  } rtm_enc_t;

  typedef enum logic [1:0] {
    MOD_DIRECT, MOD_FSK, MOD_PSK_CHANGE, MOD_PSK_ONE
  } rtm_mod_t;

  // Carrier cycles per data bit for each rate-select code.
  function automatic logic [7:0] rateDivisor(input logic [2:0] sel);
    case (sel)
      3'h0: rateDivisor = 8'h08;
      3'h1: rateDivisor = 8'h10;
      3'h2: rateDivisor = 8'h20;
      3'h3: rateDivisor = 8'h28;
      3'h4: rateDivisor = 8'h32;
      3'h5: rateDivisor = 8'h40;
      3'h6: rateDivisor = 8'h64;
      default: rateDivisor = 8'h80;
    endcase
  endfunction

endpackage

// ===== rtl/rtm_fifo_if.sv
// Bit FIFO handshake between the stream reader and the encoder.
// Assumes both sides run on the reference clock.
`timescale 1ns/10ps
`default_nettype none
interface rtm_fifo_if;
  logic wrValid;
  logic wrReady;
  logic wrData;
  logic rdValid;
  logic rdReady;
  logic rdData;
  modport store (input wrValid, output wrReady, input wrData,
                 output rdValid, input rdReady, output rdData);
  modport user  (output wrValid, input wrReady, output wrData,
                 input rdValid, output rdReady, input rdData);
endinterface
`default_nettype wire

// ===== rtl/rtm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module rtm_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  rtm_fifo_if.store bus
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             doWrite;
  logic             doRead;

  assign bus.wrReady = (count_q != (AW+1)'(DEPTH));
  assign bus.rdValid = (count_q != '0);
  assign bus.rdData  = memQ[rdPtr_q];
  assign doWrite     = bus.wrValid & bus.wrReady;
  assign doRead      = bus.rdValid & bus.rdReady;

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      memQ[wrPtr_q] <= bus.wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // rtm_fifo
`default_nettype wire

// ===== rtl/rtm_tag_top.sv
// Passive tag stream engine: config, OTP array, encoder and modulator.
// Assumes the carrier, sensor and supply-good pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module rtm_tag_top (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        carrierClock,
  input  wire logic        sensorIn,
  input  wire logic        supplyGood,
  output var  logic        coilModulate,
  output var  logic        dataRateClock
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] carrierSync_q;
  logic       carrierDly_q;
  logic [1:0] sensorSync_q;
  logic [1:0] supplySync_q;
  logic       carrierTick;
  logic       run;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrierSync_q <= 2'h0;
      carrierDly_q  <= 1'b0;
      sensorSync_q  <= 2'h0;
      supplySync_q  <= 2'h0;
    end else begin
      carrierSync_q <= {carrierSync_q[0], carrierClock};
      carrierDly_q  <= carrierSync_q[1];
      sensorSync_q  <= {sensorSync_q[0], sensorIn};
      supplySync_q  <= {supplySync_q[0], supplyGood};
    end
  end

  assign carrierTick = carrierSync_q[1] & ~carrierDly_q;
  assign run         = supplySync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and register file.

  logic [11:0]  cfg_q;
  logic [127:0] array_q;
  logic         lock_q;
  logic [6:0]   bitIdx_q;
  logic         access;
  logic         doWrite;
  logic         addrOk;
  logic         refused;
  logic [31:0]  readValue;
  logic [1:0]   wordSel;

  assign access  = psel & penable;
  assign doWrite = access & pready & pwrite;
  assign wordSel = paddr[3:2];

  // True for an aligned word address inside the array window.
  function automatic logic isDataAddr(input logic [7:0] addr);
    isDataAddr = (addr >= rtm_pkg::DATA0_ADDR) &&
                 (addr <= rtm_pkg::DATA3_ADDR) && (addr[1:0] == 2'h0);
  endfunction

  always_comb begin
    addrOk    = 1'b1;
    readValue = 32'h0000_0000;
    if (paddr == rtm_pkg::CFG_ADDR) begin
      readValue[11:0] = cfg_q;
      readValue[rtm_pkg::LOCK_BIT] = lock_q;
    end else if (paddr == rtm_pkg::CTRL_ADDR) begin
      readValue = 32'h0000_0000;
    end else if (paddr == rtm_pkg::STATUS_ADDR) begin
      readValue[rtm_pkg::STAT_LOCK_BIT]   = lock_q;
      readValue[rtm_pkg::STAT_RUN_BIT]    = run;
      readValue[rtm_pkg::STAT_SENSOR_BIT] = sensorSync_q[1];
      readValue[rtm_pkg::STAT_CNT_LO +: 7] = bitIdx_q;
    end else if (isDataAddr(paddr)) begin
      readValue = array_q[wordSel*32 +: 32];
    end else begin
      addrOk = 1'b0;
    end
  end

  // Writes to the configuration or array after locking are refused.
  assign refused = pwrite & lock_q & (paddr != rtm_pkg::STATUS_ADDR);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & (~addrOk | refused);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= readValue;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= rtm_pkg::CFG_RESET;
    end else if (doWrite && !lock_q && paddr == rtm_pkg::CFG_ADDR) begin
      cfg_q <= pwdata[11:0];
      cfg_q[rtm_pkg::ZERO_BIT] <= 1'b0;
      cfg_q[rtm_pkg::LOCK_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      array_q <= '0;
    end else if (doWrite && !lock_q && isDataAddr(paddr)) begin
      array_q[wordSel*32 +: 32] <= pwdata;
    end
  end

  // Once set, only reset_n clears the lock; supplyGood low leaves it set.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= 1'b0;
    end else if (doWrite && paddr == rtm_pkg::CTRL_ADDR &&
                 pwdata[rtm_pkg::CTRL_LOCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields.

  logic       longStream;
  logic [2:0] rateSel;
  logic       pskDiv4;
  logic [7:0] bitPeriod;
  logic [7:0] halfPeriod;
  logic [6:0] lastIdx;
  rtm_pkg::rtm_enc_t encMode;
  rtm_pkg::rtm_mod_t modMode;

  assign longStream = cfg_q[rtm_pkg::LEN_BIT];
  assign rateSel    = cfg_q[rtm_pkg::RATE_LO_BIT +: 3];
  assign encMode    = rtm_pkg::rtm_enc_t'(cfg_q[rtm_pkg::ENC_LO_BIT +: 2]);
  assign modMode    = rtm_pkg::rtm_mod_t'(cfg_q[rtm_pkg::MOD_LO_BIT +: 2]);
  assign pskDiv4    = cfg_q[rtm_pkg::PSKDIV_BIT];
  assign bitPeriod  = rtm_pkg::rateDivisor(rateSel);
  assign halfPeriod = {1'b0, bitPeriod[7:1]};
  assign lastIdx    = longStream ? 7'(rtm_pkg::MEM_BITS - 1)
                                 : 7'(rtm_pkg::SHORT_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Array reader into the bit FIFO.

  rtm_fifo_if fifoBus ();

  rtm_fifo #(
    .WIDTH (1),
    .DEPTH (rtm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .bus     (fifoBus.store)
  );

  assign fifoBus.wrValid = run;
  assign fifoBus.wrData  = array_q[bitIdx_q];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bitIdx_q <= 7'h00;
    end else if (!run) begin
      bitIdx_q <= 7'h00;
    end else if (fifoBus.wrReady) begin
      if (bitIdx_q == lastIdx) begin
        bitIdx_q <= 7'h00;
      end else begin
        bitIdx_q <= bitIdx_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data rate timing from the carrier.

  logic [7:0] rateCnt_q;
  logic       bitStart;
  logic       bitMid;
  logic       rateStep;

  // The bit timing waits at a bit start until the FIFO holds a bit, so the
  // encoder never loads the stale output of an empty FIFO.
  assign bitStart = run & carrierTick & (rateCnt_q == 8'h00) &
                    fifoBus.rdValid;
  assign bitMid   = run & carrierTick & (rateCnt_q == halfPeriod);
  assign rateStep = run & carrierTick &
                    ((rateCnt_q != 8'h00) | fifoBus.rdValid);
  assign fifoBus.rdReady = bitStart;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rateCnt_q <= 8'h00;
    end else if (!run) begin
      rateCnt_q <= 8'h00;
    end else if (rateStep) begin
      if (rateCnt_q >= bitPeriod - 8'h01) begin
        rateCnt_q <= 8'h00;
      end else begin
        rateCnt_q <= rateCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataRateClock <= 1'b0;
    end else if (!run) begin
      dataRateClock <= 1'b0;
    end else if (rateStep) begin
      dataRateClock <= (rateCnt_q < halfPeriod);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoder.

  logic curBit_q;
  logic encLevel_q;
  logic txLevel;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      curBit_q   <= 1'b0;
      encLevel_q <= 1'b0;
    end else if (!run) begin
      curBit_q   <= 1'b0;
      encLevel_q <= 1'b0;
    end else if (bitStart) begin
      curBit_q <= fifoBus.rdData;
      case (encMode)
        rtm_pkg::ENC_DIRECT:       encLevel_q <= fifoBus.rdData;
        rtm_pkg::ENC_DIFF_BIPHASE: encLevel_q <= ~encLevel_q;
        rtm_pkg::ENC_MANCHESTER:   encLevel_q <= fifoBus.rdData;
        default:                   encLevel_q <= ~fifoBus.rdData;
      endcase
    end else if (bitMid) begin
      case (encMode)
        rtm_pkg::ENC_DIRECT:       encLevel_q <= curBit_q;
        rtm_pkg::ENC_DIFF_BIPHASE: encLevel_q <= encLevel_q ^ ~curBit_q;
        rtm_pkg::ENC_MANCHESTER:   encLevel_q <= ~curBit_q;
        default:                   encLevel_q <= curBit_q;
      endcase
    end
  end

  // Sensor low inverts the encoded stream ahead of the modulator.
  assign txLevel = encLevel_q ^ ~sensorSync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Modulator.

  logic [7:0] fskCnt_q;
  logic       fskLevel_q;
  logic [1:0] pskCnt_q;
  logic       pskPhase_q;
  logic       prevTx_q;
  logic       edgeSeen_q;
  logic [7:0] fskDiv;
  logic       pskSub;
  logic       modNext;

  assign fskDiv = txLevel ? rtm_pkg::FSK_ONE_DIV : rtm_pkg::FSK_ZERO_DIV;
  assign pskSub = pskDiv4 ? pskCnt_q[1] : pskCnt_q[0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fskCnt_q   <= 8'h00;
      fskLevel_q <= 1'b0;
      pskCnt_q   <= 2'h0;
    end else if (!run) begin
      fskCnt_q   <= 8'h00;
      fskLevel_q <= 1'b0;
      pskCnt_q   <= 2'h0;
    end else if (carrierTick) begin
      pskCnt_q <= pskCnt_q + 2'h1;
      if (fskCnt_q >= {1'b0, fskDiv[7:1]} - 8'h01) begin
        fskCnt_q   <= 8'h00;
        fskLevel_q <= ~fskLevel_q;
      end else begin
        fskCnt_q <= fskCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pskPhase_q <= 1'b0;
      prevTx_q   <= 1'b0;
      edgeSeen_q <= 1'b0;
    end else if (!run) begin
      pskPhase_q <= 1'b0;
      prevTx_q   <= 1'b0;
      edgeSeen_q <= 1'b0;
    end else begin
      prevTx_q   <= txLevel;
      edgeSeen_q <= bitStart;
      if (modMode == rtm_pkg::MOD_PSK_CHANGE && txLevel != prevTx_q) begin
        pskPhase_q <= ~pskPhase_q;
      end else if (modMode == rtm_pkg::MOD_PSK_ONE && edgeSeen_q &&
                   txLevel) begin
        pskPhase_q <= ~pskPhase_q;
      end
    end
  end

  always_comb begin
    case (modMode)
      rtm_pkg::MOD_DIRECT: modNext = txLevel;
      rtm_pkg::MOD_FSK:    modNext = fskLevel_q;
      default:             modNext = pskSub ^ pskPhase_q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      coilModulate <= 1'b0;
    end else begin
      coilModulate <= run & modNext;
    end
  end

endmodule // rtm_tag_top
`default_nettype wire

// ===== verification/rtm_tag_props.sv
// Checker for the tag top: APB timing, lock refusal and stream timing.
// Assumes it is bound to rtm_tag_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module rtm_tag_props (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        carrierClock,
  input wire logic        sensorIn,
  input wire logic        supplyGood,
  input wire logic        coilModulate,
  input wire logic        dataRateClock
);
  logic       lockWr_q;
  logic       carrOld_q;
  logic [3:0] quiet_q;
  logic       rd;
  assign rd = pready && !pwrite;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lockWr_q <= 1'b0;
    end else if (pready && pwrite && !pslverr && pwdata[0] &&
                 paddr == rtm_pkg::CTRL_ADDR) begin
      lockWr_q <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrOld_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      carrOld_q <= carrierClock;
      if (carrierClock != carrOld_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_zero;
    rd && paddr == rtm_pkg::CFG_ADDR |-> !prdata[rtm_pkg::ZERO_BIT];
  endproperty
  a_zero: assert property (p_zero)
    else $error("Zero bit read as one.");
  property p_lock;
    rd && lockWr_q && paddr == rtm_pkg::CFG_ADDR |-> prdata[11];
  endproperty
  a_lock: assert property (p_lock)
    else $error("Lock bit not shown.");
  property p_refuse;
    pready && pwrite && lockWr_q && (paddr == rtm_pkg::CFG_ADDR ||
      paddr[7:4] == 4'h1) |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("Write accepted after lock.");
  property p_rate;
    $rose(dataRateClock) |-> dataRateClock [*8];
  endproperty
  a_rate: assert property (p_rate)
    else $error("Data clock high too short.");
  property p_quiet;
    quiet_q > 4'h9 |-> $stable(dataRateClock) && $stable(coilModulate);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Stream moved without carrier.");
  property p_supply;
    !supplyGood [*5] |-> !coilModulate;
  endproperty
  a_supply: assert property (p_supply)
    else $error("Coil driven without supply.");
  property p_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Ready not in second access cycle.");
  property p_single;
    pready |=> !pready;
  endproperty
  a_single: assert property (p_single)
    else $error("Ready longer than one cycle.");
  property p_hole;
    rd && paddr == 8'h0C |-> pslverr && prdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole)
    else $error("Unmapped read not refused.");
  c_lock: cover property (lockWr_q && pready && pslverr);
  c_inv: cover property ($rose(dataRateClock) && !sensorIn);
  c_sub: cover property ($rose(coilModulate) && dataRateClock);
endmodule // rtm_tag_props
bind rtm_tag_top rtm_tag_props u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .carrierClock(carrierClock),
  .sensorIn(sensorIn), .supplyGood(supplyGood),
  .coilModulate(coilModulate), .dataRateClock(dataRateClock));
`default_nettype wire

// ===== verification/rtm_reader_model.sv
// Reader model: makes the carrier and counts coil modulation edges.
// Assumes the bench gates the carrier to mimic entering the field.
`timescale 1ns/10ps
`default_nettype none
module rtm_reader_model (
  input  wire logic runCarrier,
  input  wire logic coilModulate,
  output var  logic carrierClock,
  output var  int   coilEdges
);
  initial carrierClock = 1'b0;
  initial coilEdges = 0;
  // The carrier stands still outside the field.
  always #160 if (runCarrier) carrierClock = ~carrierClock;
  always @(posedge coilModulate) coilEdges = coilEdges + 1;
endmodule // rtm_reader_model
`default_nettype wire

// ===== verification/rtm_tag_top_tb.sv
// Bench: APB register checks, then stream and subcarrier checks per mode.
// Assumes the reader model drives the carrier at a 320 ns period.
`timescale 1ns/10ps
`default_nettype none
module rtm_tag_top_tb;
  localparam logic [127:0] MEM = 128'h1F350A6C93E27B4158D6C09A3E712B4F;
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         sensorIn = 1'b1;
  logic         supplyGood = 1'b0;
  logic         runCarrier = 1'b0;
  logic         carrierClock;
  logic         coilModulate;
  logic         dataRateClock;
  logic [32:0]  got;
  logic [127:0] h1;
  logic [127:0] h2;
  logic [31:0]  mcfg [3] = '{32'h10E, 32'h38E, 32'h08E};
  int           mwin [3] = '{64, 64, 80};
  int           mlo [3] = '{30, 14, 7};
  int           mhi [3] = '{34, 18, 11};
  int           coilEdges;
  int           miscompares = 0;
  int           check_count = 0;
  int           cycles = 0;
  rtm_tag_top u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .carrierClock(carrierClock),
    .sensorIn(sensorIn), .supplyGood(supplyGood),
    .coilModulate(coilModulate), .dataRateClock(dataRateClock));
  rtm_reader_model u_reader (
    .runCarrier(runCarrier), .coilModulate(coilModulate),
    .carrierClock(carrierClock), .coilEdges(coilEdges));
  //////////////////////////////////////////////////////////////////////////////
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    got = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [32:0] e,
                     input string m);
    apb(1'b0, a, 32'h0);
    chk(got, e, m);
  endtask
  task automatic restart();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    supplyGood <= 1'b0;
    runCarrier <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask
  task automatic setup(input logic [31:0] cfg, input logic s);
    int i;
    restart();
    for (i = 0; i < 4; i++)
      apb(1'b1, rtm_pkg::DATA0_ADDR + 8'(4 * i), MEM[32 * i +: 32]);
    apb(1'b1, rtm_pkg::CFG_ADDR, cfg);
    apb(1'b1, rtm_pkg::CTRL_ADDR, 32'h1);
    runCarrier <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sensorIn <= s;
    supplyGood <= 1'b1;
    repeat (2) @(posedge dataRateClock);
  endtask
  task automatic cap(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge dataRateClock);
      #660 h1[i] = coilModulate;
      #1280 h2[i] = coilModulate;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int j;
    int k;
    int n;
    int hits;
    logic b;
    logic ok;
    logic [1:0] e;
    restart();
    rdc(rtm_pkg::CFG_ADDR, {21'h0, rtm_pkg::CFG_RESET}, "cfg reset");
    apb(1'b1, rtm_pkg::CFG_ADDR, 32'h7FF);
    rdc(rtm_pkg::CFG_ADDR, 33'h3FF, "fixed zero");
    for (i = 0; i < 4; i++)
      apb(1'b1, rtm_pkg::DATA0_ADDR + 8'(4 * i), MEM[32 * i +: 32]);
    for (i = 0; i < 4; i++)
      rdc(rtm_pkg::DATA0_ADDR + 8'(4 * i), {1'b0, MEM[32 * i +: 32]},
          "mem");
    rdc(8'h0C, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, rtm_pkg::CTRL_ADDR, 32'h1);
    apb(1'b0, rtm_pkg::STATUS_ADDR, 32'h0);
    chk({32'h0, got[rtm_pkg::STAT_LOCK_BIT]}, 33'h1, "lock status");
    rdc(rtm_pkg::CFG_ADDR, 33'hBFF, "lock set");
    apb(1'b1, rtm_pkg::CFG_ADDR, 32'h0);
    chk({got[32], 32'h0}, {1'b1, 32'h0}, "cfg refused");
    rdc(rtm_pkg::CFG_ADDR, 33'hBFF, "cfg kept");
    apb(1'b1, rtm_pkg::DATA0_ADDR, 32'h0);
    chk({got[32], 32'h0}, {1'b1, 32'h0}, "data refused");
    rdc(rtm_pkg::DATA0_ADDR, {1'b0, MEM[31:0]}, "data kept");
    for (k = 0; k < 3; k++) begin
      e = k == 0 ? 2'h0 : 2'(k + 1);
      n = k == 1 ? 128 : 96;
      setup({25'h0, e, 4'h0, k == 1}, k != 1);
      cap(n);
      hits = 0;
      for (j = 0; j < n; j++) begin
        ok = 1'b1;
        for (i = 0; i < n; i++) begin
          b = MEM[(i + j) % n] ^ (k == 1);
          if (h1[i] !== (b ^ e[0]) || h2[i] !== (b ^ (e == 2'h2))) ok = 1'b0;
        end
        hits += ok;
      end
      chk(33'(hits), 33'h1, "stream");
    end
    setup(32'h20, 1'b1);
    cap(96);
    hits = 0;
    for (i = 0; i < 96; i++)
      hits += (h1[i] != h2[i]) + MEM[i] + (i > 0 && h1[i] == h2[i - 1]);
    chk(33'(hits), 33'h60, "biphase");
    for (k = 0; k < 3; k++) begin
      setup(mcfg[k], 1'b1);
      n = coilEdges;
      #(320 * mwin[k]);
      n = coilEdges - n;
      chk({32'h0, n >= mlo[k] && n <= mhi[k]}, 33'h1, "subcarrier");
    end
    finish_test();
  end
endmodule // rtm_tag_top_tb
`default_nettype wire
